// ==== shared/rtc_sram_pkg.sv ====
// Constants and types for the timekeeping SRAM host port controller
// Function
// - Host holds address stable through write
// - Host keeps recovery gap before next cycle
// - Host holds data around end of write
// - Host holds strobes inactive during power-up; reset drives mem_sel_n and mem_str_n high but mem_drv_n low
// - Host avoids bus contention on two-wire control
package rtc_sram_pkg;

  // ****************
  // Geometry
  // ****************
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam logic [10:0] ADDR_YEAR = 11'h7ff;
  localparam logic [10:0] ADDR_MONTH = 11'h7fe;
  localparam logic [10:0] ADDR_DATE = 11'h7fd;
  localparam logic [10:0] ADDR_DAY = 11'h7fc;
  localparam logic [10:0] ADDR_HOUR = 11'h7fb;
  localparam logic [10:0] ADDR_MINUTES = 11'h7fa;
  localparam logic [10:0] ADDR_SECONDS = 11'h7f9;
  localparam logic [10:0] ADDR_CONTROL = 11'h7f8;

  // ****************
  // Timing (fastest grade), 4 ns clock
  // ****************
  localparam int CLK_PERIOD_NS = 4;
  localparam int READ_ACCESS_NS = 250;
  localparam int WRITE_PULSE_NS = 160;
  localparam int WRITE_RECOVERY_NS = 10;
  localparam int INPUT_LEAD_TIME_NS = 100;
  localparam int INPUT_KEEP_TIME_NS = 0;
  localparam int STROBE_TO_FLOAT_DELAY_NS = 80;
  localparam int OUTPUT_FLOAT_NS = 50;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD_CYC = (INPUT_LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (STROBE_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = (OUTPUT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_CYC = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int KEEP_CYC = (INPUT_KEEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int CNT_W = 8;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RD = 6'b000010,
    ST_WFLT = 6'b000100,
    ST_WR = 6'b001000,
    ST_KEEP = 6'b010000,
    ST_RECOV = 6'b100000
  } phase_e;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_s;

  typedef struct packed {
    logic sel_n;
    logic drv_n;
    logic str_n;
  } strobe_s;

endpackage

// ==== rtl/rtc_sram_host.sv ====
// Host-side controller for the byte-wide timekeeping SRAM port
`timescale 1ns/100ps
module rtc_sram_host
  import rtc_sram_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic alt_variant,
  input wire logic req_valid,
  input wire req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic mem_sel_n,
  output logic mem_drv_n,
  output logic mem_str_n,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe,
  input wire logic [DATA_W-1:0] mem_dq_i
);

  // ****************
  // State
  // ****************
  phase_e state_r;
  logic [CNT_W-1:0] cnt_r;
  logic alt_r;
  strobe_s strb_r;
  logic [DATA_W-1:0] dq_s1_r;
  logic [DATA_W-1:0] dq_s2_r;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  assign mem_sel_n = strb_r.sel_n;
  assign mem_drv_n = strb_r.drv_n;
  assign mem_str_n = strb_r.str_n;

  // Pin data is asynchronous; two stages before use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
    end else begin
      dq_s1_r <= mem_dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ****************
  // Sequencer
  // ****************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      alt_r <= 1'b0;
      strb_r <= 3'b101;
      mem_addr <= 11'h000;
      mem_dq_o <= 8'h00;
      mem_dq_oe <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          req_ready <= 1'b1;
          strb_r <= '{sel_n: 1'b1, drv_n: ~alt_variant, str_n: 1'b1};
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            alt_r <= alt_variant;
            mem_addr <= req.addr;
            if (req.we) begin
              mem_dq_o <= req.wdata;
              // Alt variant: drive enable held low until the float wait ends and data is driven
              strb_r <= '{sel_n: 1'b0, drv_n: 1'b1, str_n: 1'b0};
              if (alt_variant) begin
                strb_r.drv_n <= 1'b0;
              end
              // Wait for device outputs to float before driving
              cnt_r <= cyc(FLOAT_CYC);
              state_r <= ST_WFLT;
            end else begin
              strb_r <= '{sel_n: 1'b0, drv_n: 1'b0, str_n: 1'b1};
              // Access time plus two synchroniser stages before sampling
              cnt_r <= cyc(READ_CYC + 2);
              state_r <= ST_RD;
            end
          end
        end
        ST_RD: begin
          if (cnt_r == 8'h00) begin
            // Pin value is two stages old, access time already met
            rsp_data <= dq_s2_r;
            rsp_valid <= 1'b1;
            strb_r <= '{sel_n: 1'b1, drv_n: 1'b1, str_n: 1'b1};
            cnt_r <= cyc(TURN_CYC);
            state_r <= ST_RECOV;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_WFLT: begin
          if (cnt_r == 8'h00) begin
            mem_dq_oe <= 1'b1;
            if (alt_r) begin
              strb_r.drv_n <= 1'b1;
            end
            cnt_r <= cyc((WRITE_CYC > LEAD_CYC) ? WRITE_CYC : LEAD_CYC);
            state_r <= ST_WR;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_WR: begin
          if (cnt_r == 8'h00) begin
            // Alt variant ends on the drive enable fall with strobe still low,
            // so the device never sees a read while our data is on the bus
            if (alt_r) begin
              strb_r.drv_n <= 1'b0;
            end else begin
              strb_r.str_n <= 1'b1;
            end
            cnt_r <= cyc(KEEP_CYC);
            state_r <= ST_KEEP;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_KEEP: begin
          if (cnt_r == 8'h00) begin
            mem_dq_oe <= 1'b0;
            strb_r.sel_n <= 1'b1;
            strb_r.str_n <= 1'b1;
            rsp_valid <= 1'b1;
            cnt_r <= cyc(RECOV_CYC);
            state_r <= ST_RECOV;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_RECOV: begin
          if (cnt_r == 8'h00) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************
  // Write data lead counter
  // ****************
  // Cycles of driven data inside the write pulse
  logic [CNT_W-1:0] lead_cnt_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lead_cnt_r <= 8'h00;
    end else if (state_r == ST_WR) begin
      lead_cnt_r <= lead_cnt_r + 8'h01;
    end else begin
      lead_cnt_r <= 8'h00;
    end
  end

  // ****************
  // Checks
  // ****************
  // Only our own pins are watched; the device side is not observed
  chk_addr_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_WR) |=> $stable(mem_addr)) else $error("address moved during write");
  chk_no_contention: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mem_dq_oe |-> !(!mem_sel_n && !mem_drv_n && mem_str_n)) else $error("bus contention");
  chk_data_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(mem_str_n) && !mem_sel_n |-> mem_dq_oe && $stable(mem_dq_o)) else $error("data dropped at end");
  chk_recovery: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(mem_sel_n) |-> mem_sel_n [*3]) else $error("recovery too short");
  chk_alt_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_WR) && alt_r && (cnt_r != 8'h00) |-> mem_drv_n) else $error("alt drive low in write");
  chk_read_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(state_r == ST_RD) |-> (mem_str_n && !mem_sel_n) [*8]) else $error("read cut short");

  // ****************
  // Phase checks
  // ****************
  // Idle leaves the device deselected and our drivers off
  chk_idle_safe: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_IDLE) |-> mem_sel_n && mem_str_n && !mem_dq_oe) else $error("idle not deselected");
  // Device may still drive while its outputs float
  chk_float_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_WFLT) |-> !mem_sel_n && !mem_str_n && !mem_dq_oe) else $error("drove before float");
  // Never drive while reading
  chk_read_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_RD) |-> !mem_sel_n && !mem_drv_n && mem_str_n && !mem_dq_oe) else $error("drive in read");
  // 65 = access cycles plus two synchroniser stages
  chk_read_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(state_r == ST_RD) |-> ##65 (rsp_valid && (state_r == ST_RECOV))) else $error("read answer late");
  // Data set up long enough before the write ends
  chk_write_lead: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_KEEP) |-> (lead_cnt_r >= CNT_W'(LEAD_CYC))) else $error("data lead too short");
  // Data and select still held just after the end of write
  chk_keep_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_KEEP) |-> mem_dq_oe && !mem_sel_n && $stable(mem_dq_o)) else $error("data not kept");
  // Alt variant write ended by drive enable, strobe still low
  chk_alt_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_KEEP) && alt_r |-> !mem_drv_n && !mem_str_n) else $error("alt write end wrong");
  // Basic variant write ended by the strobe
  chk_basic_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_KEEP) && !alt_r |-> mem_str_n && mem_drv_n) else $error("basic write end wrong");

endmodule

// ==== verif/rtc_sram_model.sv ====
// Behavioural timekeeping memory seen through its byte port
`timescale 1ns/100ps
module rtc_sram_model
  import rtc_sram_pkg::*;
(
  input wire logic sel_n,
  input wire logic drv_n,
  input wire logic str_n,
  input wire logic alt,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq,
  output logic [DATA_W-1:0] q,
  output logic q_oe,
  output logic viol
);
  logic [DATA_W-1:0] mem [0:2047];
  logic [ADDR_W-1:0] a0;
  logic wr;
  logic acc_ok = 1'b0;
  // ****************
  // Array access
  // ****************
  assign wr = !sel_n && !str_n && (!alt || drv_n);
  assign q_oe = !sel_n && !drv_n && str_n;
  // Until the access time has run out the pins show the inverse of the data
  assign q = acc_ok ? mem[addr] : ~mem[addr];
  always @(negedge sel_n or addr) begin
    acc_ok <= 1'b0;
    acc_ok <= #(READ_ACCESS_NS) 1'b1;
  end
  initial begin
    viol = 1'b0;
    foreach (mem[i]) mem[i] = i[7:0] ^ 8'h5a;
  end
  // Sampled late so a same-edge address update is not a false hit
  always @(posedge wr) #1 a0 = addr;
  always @(negedge wr) begin
    mem[addr] <= dq;
    if (addr !== a0) viol = 1'b1;
  end
endmodule

// ==== verif/tb_rtc_sram_host.sv ====
// Self-checking bench for the timekeeping SRAM host controller
`timescale 1ns/100ps
module tb_rtc_sram_host;
  import rtc_sram_pkg::*;
  logic clk_sys = 0, rst_n = 0, alt = 0, req_valid = 0;
  req_s req = '0;
  logic req_ready, rsp_valid, sel_n, drv_n, str_n, dq_oe, m_oe, viol;
  logic [DATA_W-1:0] rsp_data, dq_o, m_q, dq_i, flt = 8'h00;
  logic [ADDR_W-1:0] addr;
  int bad_count = 0, check_count = 0;
  always #2 clk_sys = ~clk_sys;
  // Floating bus toggles so a stale value never reads as a match
  assign dq_i = dq_oe ? dq_o : m_oe ? m_q : flt;
  always @(posedge clk_sys) flt <= ~dq_i;
  rtc_sram_host dut(.clk_sys(clk_sys), .rst_n(rst_n), .alt_variant(alt), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_sel_n(sel_n), .mem_drv_n(drv_n),
    .mem_str_n(str_n), .mem_addr(addr), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq_i));
  rtc_sram_model dev(.sel_n(sel_n), .drv_n(drv_n), .str_n(str_n), .alt(alt), .addr(addr), .dq(dq_i),
    .q(m_q), .q_oe(m_oe), .viol(viol));
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic access(input logic we, input logic [10:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 100) bad_count++;
    req_valid = 1'b1;
    req = '{we: we, addr: a, wdata: d};
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 200) bad_count++;
    q = rsp_data;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_rw(input logic v);
    logic [7:0] q;
    logic [10:0] a [4] = '{11'h000, 11'h3a5, ADDR_CONTROL, ADDR_YEAR};
    alt = v;
    foreach (a[i]) access(1'b1, a[i], 8'hc3 ^ i[7:0] ^ {7'h0, v}, q);
    foreach (a[i]) begin
      access(1'b0, a[i], 8'h00, q);
      check(q, 8'hc3 ^ i[7:0] ^ {7'h0, v});
    end
    access(1'b0, 11'h2b7, 8'h00, q);
    check(q, 8'hb7 ^ 8'h5a);
  endtask
  // Reset in the middle of a read, then a fresh read must still work
  task automatic t_reset();
    logic [7:0] q;
    while (req_ready !== 1'b1) @(negedge clk_sys);
    req_valid = 1'b1;
    req = '{we: 1'b0, addr: 11'h155, wdata: 8'h00};
    @(negedge clk_sys);
    req_valid = 1'b0;
    repeat (30) @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys);
    check({4'h0, sel_n, str_n, dq_oe, req_ready}, 8'h0c);
    rst_n = 1'b1;
    access(1'b0, 11'h123, 8'h00, q);
    check(q, 8'h23 ^ 8'h5a);
  endtask
  always @(negedge clk_sys) if (rst_n) check({7'h0, dq_oe & m_oe}, 8'h00);
  initial begin
    repeat (4) @(negedge clk_sys);
    check({6'h0, sel_n, str_n}, 8'h03);
    rst_n = 1'b1;
    t_rw(1'b0);
    t_rw(1'b1);
    t_reset();
    check({7'h0, viol}, 8'h00);
    print_verdict();
  end
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule
